// *** logic/uart_shadow_defines.svh ***
`ifndef UART_SHADOW_DEFINES_SVH
`define UART_SHADOW_DEFINES_SVH

// ==========================================================
// Register map, byte addresses
`define SHADOW_BASE 32'h5000_1130
`define SHADOW_PORT1 32'h5000_1134
`define SHADOW_PORT2 32'h5000_1138
`define SHADOW_SPAN 32'h0000_003c
`define CTRL_ADDR 32'h5000_1100
`define LINE_STATUS_ADDR 32'h5000_1104
`define INT_STATUS_ADDR 32'h5000_1108
`define INT_MASK_ADDR 32'h5000_110c

// ==========================================================
// Field positions
`define CTRL_FIFO_EN 0
`define CTRL_IR_MODE 1
`define LS_DATA_READY 0
`define LS_OVERRUN 1
`define LS_TX_EMPTY 5
`define INT_OVERRUN 0
`define INT_RX_CHAR 1
`define INT_TX_EMPTY 2

// ==========================================================
// Reset values and sizes
`define CTRL_RESET 2'h0
`define INT_MASK_RESET 3'h0
`define FIFO_DEPTH 5'h10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** logic/uart_shadow_pkg.sv ***
package uart_shadow_pkg;
	typedef logic [7:0] char_t;
	typedef enum logic [0:0] {WR_IDLE = 1'b0, WR_RESP = 1'b1} wr_state_t;
	typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_DATA = 1'b1} rd_state_t;
endpackage

// *** logic/uart_shadow_data_port.sv ***
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uart_shadow_defines.svh"
module uart_shadow_data_port (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire uart_shadow_pkg::char_t rxSerialChar,
	input wire logic rxSerialValid,
	input wire uart_shadow_pkg::char_t rxIrChar,
	input wire logic rxIrValid,
	output uart_shadow_pkg::char_t txChar,
	output logic txSerialValid,
	output logic txIrValid,
	input wire logic txReady,
	output logic irq
);
	import uart_shadow_pkg::*;

	// ==========================================================
	// Address decode
	function automatic logic isShadow(input logic [31:0] a);
		isShadow = (a >= `SHADOW_BASE) && (a <= `SHADOW_BASE + `SHADOW_SPAN)
			&& (a[1:0] == 2'h0);
	endfunction

	function automatic logic isMapped(input logic [31:0] a);
		isMapped = isShadow(a) || a == `CTRL_ADDR || a == `LINE_STATUS_ADDR
			|| a == `INT_STATUS_ADDR || a == `INT_MASK_ADDR;
	endfunction

	// ==========================================================
	// State
	char_t rxMem [16];
	char_t txMem [16];
	char_t next_rxMem [16];
	char_t next_txMem [16];
	logic [3:0] rxHead, rxTail, txHead, txTail;
	logic [3:0] next_rxHead, next_rxTail, next_txHead, next_txTail;
	logic [4:0] rxCount, txCount, next_rxCount, next_txCount;
	logic fifoEn, irMode, overrunFlag;
	logic next_fifoEn, next_irMode, next_overrunFlag;
	logic [2:0] intStatus, intMask, next_intStatus, next_intMask;
	wr_state_t wrState, next_wrState;
	rd_state_t rdState, next_rdState;
	logic awTaken, wTaken, next_awTaken, next_wTaken;
	logic [31:0] awHeld, wHeld, next_awHeld, next_wHeld;
	logic [3:0] strbHeld, next_strbHeld;
	logic [31:0] next_rdata, rdValue;
	logic [1:0] next_rresp, next_bresp;

	logic awFire, wFire, arFire, doWrite, rxArrive, rxPop, rxPush;
	logic txWrite, txPush, txPop, txActive, modeChange, rxDrop;
	logic dataReady, txHoldingEmpty;
	logic [31:0] wrAddr, wrData;
	logic [3:0] wrStrb;
	logic [4:0] limit;
	logic [2:0] events, clearBits;
	char_t rxIn;

	// ==========================================================
	// Handshakes; readies drop with the clock enable so nothing is taken
	// while state is frozen
	assign awready = clkEn && wrState == WR_IDLE && !awTaken;
	assign wready = clkEn && wrState == WR_IDLE && !wTaken;
	assign arready = clkEn && rdState == RD_IDLE;
	assign bvalid = wrState == WR_RESP;
	assign rvalid = rdState == RD_DATA;
	assign awFire = awvalid && awready;
	assign wFire = wvalid && wready;
	assign arFire = arvalid && arready;
	assign wrAddr = awTaken ? awHeld : awaddr;
	assign wrData = wTaken ? wHeld : wdata;
	assign wrStrb = wTaken ? strbHeld : wstrb;
	// Address and data may arrive in either order
	assign doWrite = clkEn && wrState == WR_IDLE
		&& (awTaken || awFire) && (wTaken || wFire);

	// Line side and queue control
	assign rxIn = irMode ? rxIrChar : rxSerialChar;
	assign rxArrive = clkEn && (irMode ? rxIrValid : rxSerialValid);
	assign dataReady = rxCount != 5'h0;
	assign txHoldingEmpty = txCount == 5'h0;
	// Without FIFOs each direction behaves as a single holding slot
	assign limit = fifoEn ? `FIFO_DEPTH : 5'h1;
	assign rxPop = arFire && isShadow(araddr) && dataReady;
	assign rxPush = rxArrive && (rxCount < limit || rxPop);
	assign rxDrop = rxArrive && !rxPush;
	// Only the low byte lane carries a character
	assign txWrite = doWrite && isShadow(wrAddr) && wrStrb[0];
	assign txActive = clkEn && !txHoldingEmpty;
	assign txPop = txActive && txReady;
	assign txPush = txWrite && (txCount < limit || txPop);
	assign txChar = txMem[txHead];
	assign txSerialValid = txActive && !irMode;
	assign txIrValid = txActive && irMode;
	assign modeChange = doWrite && wrAddr == `CTRL_ADDR && wrStrb[0]
		&& wrData[`CTRL_FIFO_EN] != fifoEn;
	assign clearBits = (doWrite && wrAddr == `INT_STATUS_ADDR && wrStrb[0])
		? wrData[2:0] : 3'h0;
	assign events[`INT_OVERRUN] = rxDrop;
	assign events[`INT_RX_CHAR] = rxPush;
	assign events[`INT_TX_EMPTY] = txPop && txCount == 5'h1 && !txPush;
	assign irq = |(intStatus & intMask);

	// ==========================================================
	// Read value decode; upper bits of every register read as zero
	always_comb begin
		rdValue = 32'h0;
		if (isShadow(araddr)) begin
			rdValue[7:0] = rxMem[rxHead];
		end else if (araddr == `CTRL_ADDR) begin
			rdValue[`CTRL_FIFO_EN] = fifoEn;
			rdValue[`CTRL_IR_MODE] = irMode;
		end else if (araddr == `LINE_STATUS_ADDR) begin
			rdValue[`LS_DATA_READY] = dataReady;
			rdValue[`LS_OVERRUN] = overrunFlag;
			rdValue[`LS_TX_EMPTY] = txHoldingEmpty;
		end else if (araddr == `INT_STATUS_ADDR) begin
			rdValue[2:0] = intStatus;
		end else if (araddr == `INT_MASK_ADDR) begin
			rdValue[2:0] = intMask;
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		next_rxMem = rxMem;
		next_txMem = txMem;
		next_rxHead = rxHead;
		next_rxTail = rxTail;
		next_txHead = txHead;
		next_txTail = txTail;
		next_fifoEn = fifoEn;
		next_irMode = irMode;
		next_intMask = intMask;
		next_wrState = wrState;
		next_rdState = rdState;
		next_awTaken = awTaken;
		next_wTaken = wTaken;
		next_awHeld = awHeld;
		next_wHeld = wHeld;
		next_strbHeld = strbHeld;
		next_rdata = rdata;
		next_rresp = rresp;
		next_bresp = bresp;
		// Set wins over a same-cycle write-one clear
		next_intStatus = (intStatus & ~clearBits) | events;
		// Line status overrun clears when software reads line status
		next_overrunFlag = overrunFlag;
		if (arFire && araddr == `LINE_STATUS_ADDR) begin
			next_overrunFlag = 1'b0;
		end
		if (rxArrive && !rxPush) begin
			next_overrunFlag = 1'b1;
		end
		// Receive side
		if (rxPop) begin
			next_rxHead = rxHead + 4'h1;
		end
		if (rxPush) begin
			next_rxMem[rxTail] = rxIn;
			next_rxTail = rxTail + 4'h1;
		end else if (rxDrop && !fifoEn) begin
			next_rxMem[rxHead] = rxIn;
		end
		next_rxCount = rxCount + {4'h0, rxPush} - {4'h0, rxPop};
		// Transmit side; a full FIFO silently drops the write
		if (txPop) begin
			next_txHead = txHead + 4'h1;
		end
		if (txPush) begin
			next_txMem[txTail] = wrData[7:0];
			next_txTail = txTail + 4'h1;
		end else if (txWrite && !fifoEn) begin
			next_txMem[txHead] = wrData[7:0];
		end
		next_txCount = txCount + {4'h0, txPush} - {4'h0, txPop};
		// Write channel
		if (awFire) begin
			next_awTaken = 1'b1;
			next_awHeld = awaddr;
		end
		if (wFire) begin
			next_wTaken = 1'b1;
			next_wHeld = wdata;
			next_strbHeld = wstrb;
		end
		if (doWrite) begin
			next_awTaken = 1'b0;
			next_wTaken = 1'b0;
			next_wrState = WR_RESP;
			next_bresp = isMapped(wrAddr) ? `RESP_OKAY : `RESP_SLVERR;
			if (wrAddr == `CTRL_ADDR && wrStrb[0]) begin
				next_fifoEn = wrData[`CTRL_FIFO_EN];
				next_irMode = wrData[`CTRL_IR_MODE];
			end
			if (wrAddr == `INT_MASK_ADDR && wrStrb[0]) begin
				next_intMask = wrData[2:0];
			end
		end else if (wrState == WR_RESP && bready) begin
			next_wrState = WR_IDLE;
		end
		// Read channel
		if (arFire) begin
			next_rdState = RD_DATA;
			next_rdata = rdValue;
			next_rresp = isMapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rdState == RD_DATA && rready) begin
			next_rdState = RD_IDLE;
		end
		// Changing the FIFO mode flushes both queues
		if (modeChange) begin
			next_rxHead = 4'h0;
			next_rxTail = 4'h0;
			next_rxCount = 5'h0;
			next_txHead = 4'h0;
			next_txTail = 4'h0;
			next_txCount = 5'h0;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < 16; i++) begin
				rxMem[i] <= 8'h00;
				txMem[i] <= 8'h00;
			end
			rxHead <= 4'h0;
			rxTail <= 4'h0;
			txHead <= 4'h0;
			txTail <= 4'h0;
			rxCount <= 5'h0;
			txCount <= 5'h0;
			{irMode, fifoEn} <= `CTRL_RESET;
			overrunFlag <= 1'b0;
			intStatus <= 3'h0;
			intMask <= `INT_MASK_RESET;
			wrState <= WR_IDLE;
			rdState <= RD_IDLE;
			awTaken <= 1'b0;
			wTaken <= 1'b0;
			awHeld <= 32'h0;
			wHeld <= 32'h0;
			strbHeld <= 4'h0;
			rdata <= 32'h0;
			rresp <= `RESP_OKAY;
			bresp <= `RESP_OKAY;
		end else if (clkEn) begin
			rxMem <= next_rxMem;
			txMem <= next_txMem;
			rxHead <= next_rxHead;
			rxTail <= next_rxTail;
			txHead <= next_txHead;
			txTail <= next_txTail;
			rxCount <= next_rxCount;
			txCount <= next_txCount;
			fifoEn <= next_fifoEn;
			irMode <= next_irMode;
			overrunFlag <= next_overrunFlag;
			intStatus <= next_intStatus;
			intMask <= next_intMask;
			wrState <= next_wrState;
			rdState <= next_rdState;
			awTaken <= next_awTaken;
			wTaken <= next_wTaken;
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			strbHeld <= next_strbHeld;
			rdata <= next_rdata;
			rresp <= next_rresp;
			bresp <= next_bresp;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_alias_read_ok: assert property (
		arFire && isShadow(araddr) |=> rvalid && rresp == `RESP_OKAY)
		else $error("shadow alias read not answered okay");
	a_rx_source_mode: assert property (
		rxArrive && rxCount == 5'h0 && !modeChange
		|=> dataReady && rxMem[rxHead] == $past(rxIn))
		else $error("received char not taken from selected input");
	a_rx_overwrite: assert property (
		!fifoEn && rxCount == 5'h1 && rxArrive && !rxPop && !modeChange
		|=> rxCount == 5'h1 && overrunFlag && rxMem[rxHead] == $past(rxIn))
		else $error("single buffer not overwritten with overrun");
	a_rx_pop_head: assert property (
		clkEn && rxPop && !rxArrive && !modeChange
		|=> rxCount == $past(rxCount) - 5'h1)
		else $error("shadow read did not pop receive queue");
	a_rx_full_keep: assert property (
		fifoEn && rxCount == `FIFO_DEPTH && rxArrive && !rxPop && !modeChange
		|=> rxCount == `FIFO_DEPTH && $stable(rxTail) && intStatus[0])
		else $error("full receive FIFO not preserved on overrun");
	a_tx_holding_empty_clear: assert property (
		!fifoEn && txHoldingEmpty && txWrite && !modeChange
		|=> !txHoldingEmpty && txChar == $past(wrData[7:0]))
		else $error("holding empty flag not cleared by write");
	a_tx_replace: assert property (
		!fifoEn && txCount == 5'h1 && txWrite && !txPop && !modeChange
		|=> txCount == 5'h1 && txChar == $past(wrData[7:0]))
		else $error("held character not replaced");
	a_tx_depth: assert property (
		fifoEn && txCount < `FIFO_DEPTH && txWrite && !txPop && !modeChange
		|=> txCount == $past(txCount) + 5'h1)
		else $error("transmit FIFO refused a write below depth");
	a_tx_full_drop: assert property (
		fifoEn && txCount == `FIFO_DEPTH && txWrite && !txPop && !modeChange
		|=> txCount == `FIFO_DEPTH && $stable(txTail))
		else $error("write to full transmit FIFO not discarded");
	a_upper_zero: assert property (
		rvalid |-> rdata[31:8] == 24'h0)
		else $error("reserved read bits not zero");
endmodule
`default_nettype wire

// *** verification/uart_line_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Remote transceiver on the line side
module uart_line_partner (
	input wire logic clk,
	input wire logic stall,
	input wire uart_shadow_pkg::char_t txChar,
	input wire logic txSerialValid,
	input wire logic txIrValid,
	output logic txReady,
	output uart_shadow_pkg::char_t rxSerialChar,
	output logic rxSerialValid,
	output uart_shadow_pkg::char_t rxIrChar,
	output logic rxIrValid
);
	import uart_shadow_pkg::*;
	char_t got[$];
	logic gotIr[$];
	// Stalling lets the transmit queue fill up
	assign txReady = ~stall;
	// Log one character per handshake edge
	always @(posedge clk) begin
		if (txReady && (txSerialValid || txIrValid)) begin
			got.push_back(txChar);
			gotIr.push_back(txIrValid);
		end
	end
	initial begin
		rxSerialChar = 8'h00;
		rxIrChar = 8'h00;
		rxSerialValid = 1'b0;
		rxIrValid = 1'b0;
	end
	// One-cycle pulse; data inverted afterwards so a late sample shows
	task automatic send(input char_t c, input logic ir);
		@(posedge clk);
		if (ir) begin
			rxIrChar <= c;
			rxIrValid <= 1'b1;
		end else begin
			rxSerialChar <= c;
			rxSerialValid <= 1'b1;
		end
		@(posedge clk);
		rxSerialValid <= 1'b0;
		rxIrValid <= 1'b0;
		rxSerialChar <= ~c;
		rxIrChar <= ~c;
	endtask
endmodule
`default_nettype wire

// *** verification/tb_uart_shadow_data_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "uart_shadow_defines.svh"
module tb_uart_shadow_data_port;
	import uart_shadow_pkg::*;
	logic clk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, rxSerialValid, rxIrValid;
	logic txSerialValid, txIrValid, txReady, irq, stall, clkEn;
	logic [31:0] awaddr, wdata, araddr, rdata, seed, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r, br;
	char_t rxSerialChar, rxIrChar, txChar;
	char_t q[17];
	int nErrors, cmpCount;
	uart_shadow_data_port uart_shadow_data_port_i (.clk, .reset,
		.clkEn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .rxSerialChar,
		.rxSerialValid, .rxIrChar, .rxIrValid, .txChar, .txSerialValid,
		.txIrValid, .txReady, .irq);
	uart_line_partner uart_line_partner_i (.clk, .stall, .txChar,
		.txSerialValid, .txIrValid, .txReady, .rxSerialChar,
		.rxSerialValid, .rxIrChar, .rxIrValid);
	// ==========================================================
	// Clock, helpers and bus tasks
	always #2 clk = ~clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Shadow word carries the character in the low byte only
	function automatic logic [31:0] shadowWord(input char_t c);
		return {24'h000000, c};
	endfunction
	function automatic logic [31:0] aliasAddr(input int i);
		return `SHADOW_BASE + 32'(4 * i);
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmpCount++;
		if (g !== e) begin
			nErrors++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic summarize();
		if (nErrors == 0 && cmpCount > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Each channel released at the edge its ready is seen
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 64);
		chk(n < 64, 1'b1);
		// Response taken at the edge it is seen; bready stays high so
		// back-to-back calls never reassign it in one time step
		br = bresp;
	endtask
	task automatic rd(input logic [31:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 64);
		chk(n < 64, 1'b1);
		d = rdata;
		r = rresp;
	endtask
	// Polls until the transmit queue reports empty
	task automatic waitTxEmpty();
		int n;
		n = 0;
		do begin
			rd(`LINE_STATUS_ADDR);
			n++;
		end while (d[`LS_TX_EMPTY] !== 1'b1 && n < 100);
		chk(d[`LS_TX_EMPTY], 1'b1);
	endtask
	// ==========================================================
	// Watchdog
	initial begin
		#200000;
		nErrors++;
		summarize();
	end
	// ==========================================================
	// Main sequence
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		seed = 32'h00006681;
		{awvalid, wvalid, bready, arvalid, rready, stall} = 6'h00;
		clkEn = 1'b1;
		{awaddr, wdata, araddr, wstrb} = 100'h0;
		nErrors = 0;
		cmpCount = 0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		rd(`SHADOW_PORT1);
		chk(d, 32'h00000000);
		rd(`SHADOW_PORT2);
		chk(d, 32'h00000000);
		rd(`LINE_STATUS_ADDR);
		chk(d[`LS_TX_EMPTY], 1'b1);
		rd(32'h5000_1200);
		chk(r, `RESP_SLVERR);
		wr(32'h5000_1200, 32'h000000ff);
		chk(br, `RESP_SLVERR);
		// FIFOs off: second character overwrites the first
		wr(`INT_MASK_ADDR, 32'h00000001);
		chk(br, `RESP_OKAY);
		q[0] = 8'(rnd());
		q[1] = 8'(rnd());
		uart_line_partner_i.send(q[0], 1'b0);
		uart_line_partner_i.send(q[1], 1'b0);
		rd(`LINE_STATUS_ADDR);
		chk(d[1:0], 2'h3);
		chk(irq, 1'b1);
		rd(`SHADOW_PORT1);
		chk(d, shadowWord(q[1]));
		rd(`LINE_STATUS_ADDR);
		chk(d[`LS_DATA_READY], 1'b0);
		wr(`INT_STATUS_ADDR, 32'h00000007);
		chk(irq, 1'b0);
		// FIFOs on: seventeenth arrival is lost
		wr(`CTRL_ADDR, 32'h00000001);
		for (int i = 0; i < 17; i++) begin
			q[i] = 8'(rnd());
			uart_line_partner_i.send(q[i], 1'b0);
		end
		rd(`LINE_STATUS_ADDR);
		chk(d[1:0], 2'h3);
		for (int i = 0; i < 16; i++) begin
			rd(aliasAddr(i));
			chk(d, shadowWord(q[i]));
		end
		rd(`LINE_STATUS_ADDR);
		chk(d[`LS_DATA_READY], 1'b0);
		// Transmit FIFO fills while the line stalls
		stall <= 1'b1;
		for (int i = 0; i < 17; i++) begin
			d = rnd();
			q[i] = d[7:0];
			wr(aliasAddr(i % 16), d);
		end
		stall <= 1'b0;
		waitTxEmpty();
		chk(uart_line_partner_i.got.size(), 16);
		chk(uart_line_partner_i.gotIr[0], 1'b0);
		for (int i = 0; i < 16; i++) begin
			chk(uart_line_partner_i.got[i], q[i]);
		end
		// FIFOs off: a second write replaces the held character
		wr(`CTRL_ADDR, 32'h00000000);
		uart_line_partner_i.got.delete();
		stall <= 1'b1;
		q[0] = 8'(rnd());
		q[1] = 8'(rnd());
		wr(`SHADOW_PORT1, shadowWord(q[0]));
		rd(`LINE_STATUS_ADDR);
		chk(d[`LS_TX_EMPTY], 1'b0);
		// Clock enable low: held character must not reach the line
		clkEn <= 1'b0;
		stall <= 1'b0;
		repeat (4) @(posedge clk);
		chk(txSerialValid, 1'b0);
		chk(arready, 1'b0);
		chk(uart_line_partner_i.got.size(), 0);
		clkEn <= 1'b1;
		stall <= 1'b1;
		wr(`SHADOW_PORT2, shadowWord(q[1]));
		stall <= 1'b0;
		waitTxEmpty();
		chk(uart_line_partner_i.got.size(), 1);
		chk(uart_line_partner_i.got[0], q[1]);
		// Infrared mode on both directions
		wr(`CTRL_ADDR, 32'h00000002);
		uart_line_partner_i.got.delete();
		uart_line_partner_i.gotIr.delete();
		q[2] = 8'(rnd());
		uart_line_partner_i.send(q[2], 1'b1);
		rd(`SHADOW_PORT2);
		chk(d, shadowWord(q[2]));
		wr(`SHADOW_PORT1, shadowWord(q[0]));
		waitTxEmpty();
		chk(uart_line_partner_i.got[0], q[0]);
		chk(uart_line_partner_i.gotIr[0], 1'b1);
		summarize();
	end
endmodule
`default_nettype wire
